// ### design/ascr_consts.svh
// Register offsets, field positions and reset values for the converter configuration bank.
// Assumes byte-wide register access over the device configuration port.
`ifndef ASCR_CONSTS_SVH
`define ASCR_CONSTS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define ASCR_ADDR_W            12
`define ASCR_ADDR_CLK_CTRL0    12'h0_029
`define ASCR_ADDR_EDGE_POS_HI  12'h0_02c
`define ASCR_ADDR_EDGE_POS_MID 12'h0_02d
`define ASCR_ADDR_EDGE_POS_LO  12'h0_02e
`define ASCR_ADDR_FSR_A_HI     12'h0_030
`define ASCR_ADDR_FSR_A_LO     12'h0_031
`define ASCR_ADDR_FSR_B_HI     12'h0_032
`define ASCR_ADDR_FSR_B_LO     12'h0_033
`define ASCR_ADDR_REF_BYPASS   12'h0_038
`define ASCR_ADDR_TSTAMP_CTRL  12'h0_03b
`define ASCR_ADDR_PRE_EMPH     12'h0_048

// ****************************************
// Reset values and field positions
// ****************************************
`define ASCR_FSR_RESET         16'ha000
`define ASCR_BYTE_RESET        8'h00
`define ASCR_BIT_REF_BYPASS    0
`define ASCR_BIT_TS_RECV_EN    0
`define ASCR_BIT_TS_LVPECL     1
`define ASCR_BIT_MAGNIFY       4
`define ASCR_PE_W              4
`define ASCR_SEL_W             4
`define ASCR_LANES             16
`define ASCR_UNMAPPED_READ     8'h00

`endif

// ### design/ascr_pkg.sv
// Types shared by the converter configuration bank.
// Assumes ascr_consts.svh is on the include path.
`include "ascr_consts.svh"

package ascr_pkg;

  // ****************************************
  // Register access and control carriers
  // ****************************************
  typedef struct packed {
    logic                      wr;
    logic                      rd;
    logic [`ASCR_ADDR_W-1:0]   addr;
    logic [7:0]                wdata;
  } ascr_req_s;

  typedef struct packed {
    logic [15:0]               fsr_a;
    logic [15:0]               fsr_b;
    logic                      ref_bypass;
    logic                      ts_recv_en;
    logic                      ts_lvpecl;
    logic                      magnify;
    logic                      auto_cal;
    logic [`ASCR_SEL_W-1:0]    delay_sel;
  } ascr_ctrl_s;

  typedef logic [`ASCR_LANES-1:0][`ASCR_PE_W-1:0] ascr_lane_pe_t;

endpackage

// ### design/ascr_edge_capture.sv
// Captures the SYSREF edge-position status word for readback.
// Assumes the raw position sampler delivers a fine and a coarse word with a strobe.
`timescale 1ns/1ps

module ascr_edge_capture (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_pos_valid,
  input  wire logic [23:0] i_pos_fine,
  input  wire logic [23:0] i_pos_coarse,
  input  wire logic        i_magnify,
  output logic [23:0]      o_pos
);
  import ascr_pkg::*;

  // status capture
  // Undefined at reset in the device; zero here keeps simulation clean.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pos <= 24'h00_0000;
    end else if (i_pos_valid) begin
      o_pos <= i_magnify ? i_pos_fine : i_pos_coarse;
    end
  end

endmodule

// ### design/ascr_config_regs.sv
// Byte-wide configuration and status bank for the converter analog and serializer controls.
// Assumes a synchronous byte port: one-cycle write or read strobes with address and data.
//
// Contract
// - Read-only 24-bit SYSREF edge position over three byte addresses.
// - Input A full-scale code, 16-bit RW, resets to 0xA000.
// - Input B full-scale code, same reset and mapping as A.
// - Reference bypass bit 0 selects supply as reference.
// - Timestamp control bit 1 selects LVPECL mode, reset zero.
// - Timestamp control bit 0 enables receiver, reset zero.
// - Four-bit pre-emphasis drives all 16 lanes, reset zero.
// - Magnify control changes edge position resolution.
// - Delay select zero means automatic SYSREF calibration.
`timescale 1ns/1ps
`include "ascr_consts.svh"

module ascr_config_regs (
  input  wire logic                    i_clk,
  input  wire logic                    i_nrst,
  input  wire ascr_pkg::ascr_req_s     i_req,
  input  wire logic                    i_pos_valid,
  input  wire logic [23:0]             i_pos_fine,
  input  wire logic [23:0]             i_pos_coarse,
  output ascr_pkg::ascr_ctrl_s         o_ctrl,
  output ascr_pkg::ascr_lane_pe_t      o_lane_pe,
  output logic [7:0]                   o_rdata,
  output logic                         o_rvalid
);
  import ascr_pkg::*;

  // ****************************************
  // Reset release
  // ****************************************
  // Reset takes hold at once but leaves on a clock edge, so every register starts on the same cycle.
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ****************************************
  // Storage
  // ****************************************
  logic [15:0]            fsr_a_q;
  logic [15:0]            fsr_b_q;
  logic [7:0]             clk_ctrl0_q;
  logic [7:0]             ref_byp_q;
  logic [7:0]             ts_ctrl_q;
  logic [7:0]             pe_q;
  logic [23:0]            edge_pos;
  logic [`ASCR_PE_W-1:0]  pe_field;

  assign pe_field = pe_q[`ASCR_PE_W-1:0];

  // The two bytes of a code land one write apart and are not shadowed, so the analog side
  // briefly sees a code made of one new and one old byte.
  // input A code
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fsr_a_q <= `ASCR_FSR_RESET;
    end else if (i_req.wr && i_req.addr == `ASCR_ADDR_FSR_A_HI) begin
      fsr_a_q[15:8] <= i_req.wdata;
    end else if (i_req.wr && i_req.addr == `ASCR_ADDR_FSR_A_LO) begin
      fsr_a_q[7:0] <= i_req.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fsr_b_q <= `ASCR_FSR_RESET;
    end else if (i_req.wr && i_req.addr == `ASCR_ADDR_FSR_B_HI) begin
      fsr_b_q[15:8] <= i_req.wdata;
    end else if (i_req.wr && i_req.addr == `ASCR_ADDR_FSR_B_LO) begin
      fsr_b_q[7:0] <= i_req.wdata;
    end
  end

  // Reserved bits store what is written, so readback matches the write.
  // Writes to the read-only edge position bytes or to unmapped addresses match no item and are dropped.
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      clk_ctrl0_q <= `ASCR_BYTE_RESET;
      ref_byp_q   <= `ASCR_BYTE_RESET;
      ts_ctrl_q   <= `ASCR_BYTE_RESET;
      pe_q        <= `ASCR_BYTE_RESET;
    end else if (i_req.wr) begin
      case (i_req.addr)
        `ASCR_ADDR_CLK_CTRL0: begin
          clk_ctrl0_q <= i_req.wdata;
        end
        `ASCR_ADDR_REF_BYPASS: begin
          ref_byp_q <= i_req.wdata;
        end
        `ASCR_ADDR_TSTAMP_CTRL: begin
          ts_ctrl_q <= i_req.wdata;
        end
        `ASCR_ADDR_PRE_EMPH: begin
          pe_q <= i_req.wdata;
        end
        default: begin
          pe_q <= pe_q;
        end
      endcase
    end
  end

  // ****************************************
  // Edge position capture
  // ****************************************
  // Magnify comes from the stored byte, so the first capture after the write already uses it.
  ascr_edge_capture u_edge (
    .i_clk        (i_clk),
    .i_rst_n      (rst_n_q),
    .i_pos_valid  (i_pos_valid),
    .i_pos_fine   (i_pos_fine),
    .i_pos_coarse (i_pos_coarse),
    .i_magnify    (clk_ctrl0_q[`ASCR_BIT_MAGNIFY]),
    .o_pos        (edge_pos)
  );

  // ****************************************
  // Control outputs
  // ****************************************
  // control word
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // Delay select resets to zero, so the automatic calibration flag resets high to agree with it.
      o_ctrl <= '{fsr_a: `ASCR_FSR_RESET, fsr_b: `ASCR_FSR_RESET, auto_cal: 1'b1, default: '0};
    end else begin
      o_ctrl.fsr_a      <= fsr_a_q;
      o_ctrl.fsr_b      <= fsr_b_q;
      o_ctrl.ref_bypass <= ref_byp_q[`ASCR_BIT_REF_BYPASS];
      o_ctrl.ts_recv_en <= ts_ctrl_q[`ASCR_BIT_TS_RECV_EN];
      o_ctrl.ts_lvpecl  <= ts_ctrl_q[`ASCR_BIT_TS_LVPECL];
      o_ctrl.magnify    <= clk_ctrl0_q[`ASCR_BIT_MAGNIFY];
      o_ctrl.auto_cal   <= (clk_ctrl0_q[`ASCR_SEL_W-1:0] == 4'h0);
      o_ctrl.delay_sel  <= clk_ctrl0_q[`ASCR_SEL_W-1:0];
    end
  end

  // A four-bit register per lane keeps each serializer's copy local instead of routing one net to all sixteen.
  // lane fan-out
  for (genvar g = 0; g < `ASCR_LANES; g++) begin : g_lane
    always_ff @(posedge i_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        o_lane_pe[g] <= 4'h0;
      end else begin
        o_lane_pe[g] <= pe_field;
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // A read and a write in one cycle both act; the read returns the byte held before the write.
  // status readback
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_rdata  <= `ASCR_UNMAPPED_READ;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_req.rd;
      if (i_req.rd) begin
        case (i_req.addr)
          `ASCR_ADDR_CLK_CTRL0: begin
            o_rdata <= clk_ctrl0_q;
          end
          `ASCR_ADDR_EDGE_POS_HI: begin
            o_rdata <= edge_pos[23:16];
          end
          `ASCR_ADDR_EDGE_POS_MID: begin
            o_rdata <= edge_pos[15:8];
          end
          `ASCR_ADDR_EDGE_POS_LO: begin
            o_rdata <= edge_pos[7:0];
          end
          `ASCR_ADDR_FSR_A_HI: begin
            o_rdata <= fsr_a_q[15:8];
          end
          `ASCR_ADDR_FSR_A_LO: begin
            o_rdata <= fsr_a_q[7:0];
          end
          `ASCR_ADDR_FSR_B_HI: begin
            o_rdata <= fsr_b_q[15:8];
          end
          `ASCR_ADDR_FSR_B_LO: begin
            o_rdata <= fsr_b_q[7:0];
          end
          `ASCR_ADDR_REF_BYPASS: begin
            o_rdata <= ref_byp_q;
          end
          `ASCR_ADDR_TSTAMP_CTRL: begin
            o_rdata <= ts_ctrl_q;
          end
          `ASCR_ADDR_PRE_EMPH: begin
            o_rdata <= pe_q;
          end
          default: begin
            o_rdata <= `ASCR_UNMAPPED_READ;
          end
        endcase
      end
    end
  end

endmodule

// ### sim/ascr_config_regs_props.sv
// Port-level assertions for the converter configuration bank.
// Assumes the byte port timing of ascr_config_regs; bound in from the foot of this file.
`timescale 1ns/1ps

module ascr_config_regs_props (
  input  wire logic                    i_clk,
  input  wire logic                    i_nrst,
  input  wire ascr_pkg::ascr_req_s     i_req,
  input  wire logic                    i_pos_valid,
  input  wire logic [23:0]             i_pos_fine,
  input  wire logic [23:0]             i_pos_coarse,
  input  wire ascr_pkg::ascr_ctrl_s    o_ctrl,
  input  wire ascr_pkg::ascr_lane_pe_t o_lane_pe,
  input  wire logic [7:0]              o_rdata,
  input  wire logic                    o_rvalid
);
  import ascr_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // A write shows on the control outputs one edge after the edge that takes it, so the checks sample them two edges later.
  sequence s_wr(logic [11:0] a);
    i_req.wr && i_req.addr == a;
  endsequence
  AST_RD_ANSWER: assert property (i_req.rd |=> o_rvalid)
    else $error("read strobe not answered");
  AST_RVALID_CAUSE: assert property (o_rvalid |-> $past(i_req.rd))
    else $error("read valid without a read");
  AST_FSR_A_HI: assert property (s_wr(12'h0_030) |-> ##2 o_ctrl.fsr_a[15:8] == $past(i_req.wdata, 2))
    else $error("input a code high byte wrong");
  AST_FSR_B_LO: assert property (s_wr(12'h0_033) |-> ##2 o_ctrl.fsr_b[7:0] == $past(i_req.wdata, 2))
    else $error("input b code low byte wrong");
  AST_REF_BYP: assert property (s_wr(12'h0_038) |-> ##2 o_ctrl.ref_bypass == $past(i_req.wdata[0], 2))
    else $error("reference bypass wrong");
  AST_TS_CTRL: assert property (s_wr(12'h0_03b) |-> ##2
    {o_ctrl.ts_lvpecl, o_ctrl.ts_recv_en} == $past(i_req.wdata[1:0], 2))
    else $error("timestamp control wrong");
  AST_PE_LANES: assert property (s_wr(12'h0_048) |-> ##2 o_lane_pe == {16{$past(i_req.wdata[3:0], 2)}})
    else $error("lane pre-emphasis wrong");
  AST_RD_ORDER: assert property (i_req.rd && i_req.addr == 12'h0_031 |=> o_rdata == o_ctrl.fsr_a[7:0])
    else $error("input a low byte readback wrong");
  AST_AUTO_CAL: assert property ($stable(o_ctrl.delay_sel) [*5] |->
    o_ctrl.auto_cal == (o_ctrl.delay_sel == 4'h0))
    else $error("automatic calibration select wrong");
  AST_CLK_CTRL: assert property (s_wr(12'h0_029) |-> ##2
    {o_ctrl.magnify, o_ctrl.delay_sel} == $past(i_req.wdata[4:0], 2))
    else $error("magnify or delay select wrong");
endmodule

bind ascr_config_regs ascr_config_regs_props i_props (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req),
  .i_pos_valid(i_pos_valid), .i_pos_fine(i_pos_fine), .i_pos_coarse(i_pos_coarse), .o_ctrl(o_ctrl),
  .o_lane_pe(o_lane_pe), .o_rdata(o_rdata), .o_rvalid(o_rvalid));

// ### sim/tb.sv
// Self-checking bench for the converter configuration bank.
// Assumes the package, the bank and its checker are compiled ahead of this file.
`timescale 1ns/1ps

module tb;
  import ascr_pkg::*;
  logic          i_clk;
  logic          i_nrst;
  logic          i_pos_valid;
  logic [23:0]   i_pos_fine;
  logic [23:0]   i_pos_coarse;
  ascr_req_s     i_req;
  ascr_ctrl_s    o_ctrl;
  ascr_lane_pe_t o_lane_pe;
  logic [7:0]    o_rdata;
  logic          o_rvalid;
  int            errors;
  int            tests_run;

  ascr_config_regs i_ascr_config_regs (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req),
    .i_pos_valid(i_pos_valid), .i_pos_fine(i_pos_fine), .i_pos_coarse(i_pos_coarse), .o_ctrl(o_ctrl),
    .o_lane_pe(o_lane_pe), .o_rdata(o_rdata), .o_rvalid(o_rvalid));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Requests change at the falling edge and are taken at the next rising edge.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_clk);
    i_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge i_clk);
    i_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge i_clk);
    i_req.rd = 1'b0;
    chk(64'(o_rvalid), 64'h1, "read valid");
    chk(64'(o_rdata), 64'(exp), "read data");
  endtask

  task automatic t_reset_values;
    logic [11:0] adr [9] = '{12'h0_030, 12'h0_031, 12'h0_032, 12'h0_033, 12'h0_038,
                             12'h0_03b, 12'h0_048, 12'h0_029, 12'h0_02f};
    logic [7:0]  val [9] = '{8'ha0, 8'h00, 8'ha0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < 9; k++) begin
      rd(adr[k], val[k]);
    end
    chk(64'(o_ctrl.auto_cal), 64'h1, "auto calibration");
    chk(o_lane_pe, 64'h0, "lane pre-emphasis");
  endtask

  task automatic t_controls;
    wr(12'h0_030, 8'h20);
    wr(12'h0_031, 8'h00);
    wr(12'h0_032, 8'hff);
    wr(12'h0_033, 8'hff);
    wr(12'h0_038, 8'h01);
    wr(12'h0_03b, 8'h02);
    wr(12'h0_048, 8'h0f);
    @(negedge i_clk);
    chk(64'(o_ctrl.fsr_a), 64'h2000, "input a code");
    chk(64'(o_ctrl.fsr_b), 64'hffff, "input b code");
    chk(64'(o_ctrl.ref_bypass), 64'h1, "reference bypass");
    chk(64'({o_ctrl.ts_lvpecl, o_ctrl.ts_recv_en}), 64'h2, "timestamp mode");
    chk(o_lane_pe, {16{4'hf}}, "lane pre-emphasis");
    wr(12'h0_03b, 8'h01);
    @(negedge i_clk);
    chk(64'({o_ctrl.ts_lvpecl, o_ctrl.ts_recv_en}), 64'h1, "timestamp enable");
    rd(12'h0_030, 8'h20);
    rd(12'h0_048, 8'h0f);
  endtask

  task automatic t_edge_pos;
    i_pos_fine = 24'h12_3456;
    i_pos_coarse = 24'hab_cdef;
    @(negedge i_clk);
    i_pos_valid = 1'b1;
    @(negedge i_clk);
    i_pos_valid = 1'b0;
    repeat (2) @(negedge i_clk);
    rd(12'h0_02c, 8'hab);
    rd(12'h0_02e, 8'hef);
    wr(12'h0_02c, 8'h55);
    rd(12'h0_02c, 8'hab);
    wr(12'h0_029, 8'h10);
    i_pos_valid = 1'b1;
    @(negedge i_clk);
    i_pos_valid = 1'b0;
    repeat (2) @(negedge i_clk);
    chk(64'(o_ctrl.magnify), 64'h1, "magnify");
    rd(12'h0_02c, 8'h12);
    rd(12'h0_02d, 8'h34);
  endtask

  task automatic t_delay_sel;
    wr(12'h0_029, 8'h05);
    repeat (2) @(negedge i_clk);
    chk(64'({o_ctrl.auto_cal, o_ctrl.delay_sel}), 64'h05, "manual delay");
    wr(12'h0_029, 8'h00);
    repeat (2) @(negedge i_clk);
    chk(64'({o_ctrl.auto_cal, o_ctrl.delay_sel}), 64'h10, "automatic delay");
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    errors = 0;
    tests_run = 0;
    i_nrst = 1'b0;
    i_req = '0;
    i_pos_valid = 1'b0;
    i_pos_fine = 24'h0;
    i_pos_coarse = 24'h0;
    repeat (5) @(negedge i_clk);
    i_nrst = 1'b1;
    repeat (3) @(negedge i_clk);
    t_reset_values();
    t_controls();
    t_edge_pos();
    t_delay_sel();
    complete_run();
  end
endmodule
